// [ecf_top.sv]
// Behaviour
// - Sample store holds 768 bytes, then stops
// - Samples accepted at 1 MHz rate
// - Decimation ratio sets store interval
// - Blanking count delays storage after burst
// - Datapath 12 bits; full mode uses two bytes
// - Mode 0x07 stores bits 10 to 3
// - Mode 0x06 stores low eight bits
// - Pulse count sets burst pulses
// - On and off counts set drive period
// - Band-pass has three two-byte coefficients
// - Low-pass has two two-byte coefficients
// - Firmware does threshold scan, not hardware
//
// Decided for this implementation: the APB register port and the register addresses.
`default_nettype none
module ecf_top (
   input wire logic core_clk_i, // System clock 50 MHz
   input wire logic rst_n_i, // Sync reset, low
   input wire logic psel, // APB select
   input wire logic penable, // APB enable
   input wire logic pwrite, // APB direction
   input wire logic [7:0] paddr, // APB byte address
   input wire logic [31:0] pwdata, // APB write data
   output logic [31:0] prdata, // APB read data
   output logic pready, // APB ready
   output logic pslverr, // APB error
   input wire logic [11:0] echo_sample_i, // Filtered echo sample
   output logic drv_a_o, // Low side driver A
   output logic drv_b_o, // Low side driver B
   output logic fifo_update_o, // Pointer update pulse
   output logic [15:0] bandpass_b1_o, // Band-pass B1 word
   output logic [15:0] bandpass_a2_o, // Band-pass A2 word
   output logic [15:0] bandpass_a3_o, // Band-pass A3 word
   output logic [15:0] lowpass_b1_o, // Low-pass B1 word
   output logic [15:0] lowpass_a2_o // Low-pass A2 word
);
   ecf_pkg::ecf_state_type st_q, st_d;
   logic [7:0] decim_q, decim_d, blank_q, blank_d, mode_q, mode_d, burst_pulse_count_q, burst_pulse_count_d;
   logic [15:0] on_a_q, on_a_d, off_a_q, off_a_d, on_b_q, on_b_d, off_b_q, off_b_d;
   logic [7:0] bandpass_b1_high_q, bandpass_b1_low_q, bandpass_a2_high_q, bandpass_a2_low_q;
   logic [7:0] bandpass_a3_high_q, bandpass_a3_low_q, lowpass_b1_high_q, lowpass_b1_low_q;
   logic [7:0] lowpass_a2_high_q, lowpass_a2_low_q;
   logic [79:0] coef_q, coef_d;
   logic [9:0] rd_ptr_q, rd_ptr_d, wr_ptr_q, wr_ptr_d;
   logic [5:0] tick_q, tick_d;
   logic [7:0] dec_q, dec_d, blk_q, blk_d;
   logic hi_q, hi_d, full_q, full_d, upd_q, upd_d, start_q, start_d;
   logic [3:0] nib_q, nib_d;
   logic [31:0] prdata_d;
   logic pready_d, pslverr_d;
   logic we;
   logic [7:0] wbyte;
   logic [7:0] ram_rdata;
   logic burst_done;
   logic acc, wr, rd;
   assign acc = psel && penable && !pready;
   assign wr = acc && pwrite;
   assign rd = acc && !pwrite;
   assign {bandpass_b1_high_q, bandpass_b1_low_q, bandpass_a2_high_q, bandpass_a2_low_q,
      bandpass_a3_high_q, bandpass_a3_low_q, lowpass_b1_high_q, lowpass_b1_low_q,
      lowpass_a2_high_q, lowpass_a2_low_q} = coef_q;

   // Register writes from the bus
   always_comb
   begin
      decim_d = decim_q;
      blank_d = blank_q;
      mode_d = mode_q;
      burst_pulse_count_d = burst_pulse_count_q;
      on_a_d = on_a_q;
      off_a_d = off_a_q;
      on_b_d = on_b_q;
      off_b_d = off_b_q;
      coef_d = coef_q;
      start_d = 1'b0;
      if (wr)
      begin
         unique case (paddr)
            ecf_pkg::ADDR_CTRL: start_d = pwdata[ecf_pkg::CTRL_START];
            ecf_pkg::ADDR_DECIM: decim_d = pwdata[7:0];
            ecf_pkg::ADDR_BLANK: blank_d = pwdata[7:0];
            ecf_pkg::ADDR_FIFO_MODE: mode_d = pwdata[7:0];
            ecf_pkg::ADDR_PULSE: burst_pulse_count_d = pwdata[7:0];
            ecf_pkg::ADDR_ON_A: on_a_d = pwdata[15:0];
            ecf_pkg::ADDR_OFF_A: off_a_d = pwdata[15:0];
            ecf_pkg::ADDR_ON_B: on_b_d = pwdata[15:0];
            ecf_pkg::ADDR_OFF_B: off_b_d = pwdata[15:0];
            ecf_pkg::ADDR_BP_B1: coef_d[79:64] = pwdata[15:0];
            ecf_pkg::ADDR_BP_A2: coef_d[63:48] = pwdata[15:0];
            ecf_pkg::ADDR_BP_A3: coef_d[47:32] = pwdata[15:0];
            ecf_pkg::ADDR_LP_B1: coef_d[31:16] = pwdata[15:0];
            ecf_pkg::ADDR_LP_A2: coef_d[15:0] = pwdata[15:0];
            default: coef_d = coef_q;
         endcase
      end
   end

   // Bus answer: one wait state, read data from the registers
   always_comb
   begin
      pready_d = acc;
      pslverr_d = 1'b0;
      prdata_d = 32'h0000_0000;
      rd_ptr_d = rd_ptr_q;
      if (acc)
      begin
         unique case (paddr)
            ecf_pkg::ADDR_CTRL: prdata_d = 32'h0000_0000;
            ecf_pkg::ADDR_DECIM: prdata_d = {24'h000000, decim_q};
            ecf_pkg::ADDR_BLANK: prdata_d = {24'h000000, blank_q};
            ecf_pkg::ADDR_FIFO_MODE: prdata_d = {24'h000000, mode_q};
            ecf_pkg::ADDR_PULSE: prdata_d = {24'h000000, burst_pulse_count_q};
            ecf_pkg::ADDR_ON_A: prdata_d = {16'h0000, on_a_q};
            ecf_pkg::ADDR_OFF_A: prdata_d = {16'h0000, off_a_q};
            ecf_pkg::ADDR_ON_B: prdata_d = {16'h0000, on_b_q};
            ecf_pkg::ADDR_OFF_B: prdata_d = {16'h0000, off_b_q};
            ecf_pkg::ADDR_BP_B1: prdata_d = {16'h0000, coef_q[79:64]};
            ecf_pkg::ADDR_BP_A2: prdata_d = {16'h0000, coef_q[63:48]};
            ecf_pkg::ADDR_BP_A3: prdata_d = {16'h0000, coef_q[47:32]};
            ecf_pkg::ADDR_LP_B1: prdata_d = {16'h0000, coef_q[31:16]};
            ecf_pkg::ADDR_LP_A2: prdata_d = {16'h0000, coef_q[15:0]};
            ecf_pkg::ADDR_STATUS: prdata_d = {12'h000, wr_ptr_q, 7'h00, full_q, st_q};
            ecf_pkg::ADDR_RD_PTR:
            begin
               prdata_d = {22'h000000, rd_ptr_q};
               if (pwrite)
               begin
                  rd_ptr_d = pwdata[9:0];
               end
            end
            ecf_pkg::ADDR_RD_DATA:
            begin
               // Firmware scans bytes for its threshold
               prdata_d = {24'h000000, ram_rdata};
               if (!pwrite)
               begin
                  rd_ptr_d = (rd_ptr_q == ecf_pkg::FIFO_LAST) ? 10'h000 : rd_ptr_q + 10'h001;
               end
            end
            default: pslverr_d = 1'b1;
         endcase
         if (pwrite)
         begin
            prdata_d = 32'h0000_0000;
         end
      end
   end

   // Pack sample per storage mode
   always_comb
   begin
      unique case (mode_q)
         ecf_pkg::MODE_MID8: wbyte = echo_sample_i[10:ecf_pkg::MID_LSB];
         ecf_pkg::MODE_LOW8: wbyte = echo_sample_i[7:0];
         default: wbyte = hi_q ? {4'h0, nib_q} : echo_sample_i[7:0];
      endcase
   end

   // Measurement sequencing: burst, blanking, decimated storage
   always_comb
   begin
      st_d = st_q;
      tick_d = (tick_q == ecf_pkg::SAMPLE_DIV - 6'h01) ? 6'h00 : tick_q + 6'h01;
      dec_d = dec_q;
      blk_d = blk_q;
      hi_d = hi_q;
      nib_d = nib_q;
      full_d = full_q;
      wr_ptr_d = wr_ptr_q;
      we = 1'b0;
      upd_d = 1'b0;
      unique case (st_q)
         ecf_pkg::ST_IDLE:
         begin
            if (start_q)
            begin
               st_d = ecf_pkg::ST_BURST;
               wr_ptr_d = 10'h000;
               full_d = 1'b0;
               hi_d = 1'b0;
            end
         end
         ecf_pkg::ST_BURST:
         begin
            if (burst_done)
            begin
               st_d = ecf_pkg::ST_BLANK;
               blk_d = blank_q;
               tick_d = 6'h00;
            end
         end
         ecf_pkg::ST_BLANK:
         begin
            if (tick_q == 6'h00)
            begin
               if (blk_q == 8'h00)
               begin
                  st_d = ecf_pkg::ST_STORE;
                  dec_d = 8'h00;
               end
               else
               begin
                  blk_d = blk_q - 8'h01;
               end
            end
         end
         ecf_pkg::ST_STORE:
         begin
            if (tick_q == 6'h00)
            begin
               dec_d = (dec_q + 8'h01 >= decim_q) ? 8'h00 : dec_q + 8'h01;
            end
            // Upper byte of a 12-bit pair follows its low byte at once, same sample
            if (hi_q || (tick_q == 6'h00 && dec_q == 8'h00))
            begin
               we = 1'b1;
               upd_d = 1'b1;
               hi_d = (mode_q != ecf_pkg::MODE_MID8) && (mode_q != ecf_pkg::MODE_LOW8) && !hi_q;
               nib_d = echo_sample_i[11:8];
               wr_ptr_d = wr_ptr_q + 10'h001;
               if (wr_ptr_q == ecf_pkg::FIFO_LAST)
               begin
                  full_d = 1'b1;
                  st_d = ecf_pkg::ST_IDLE;
               end
            end
         end
      endcase
   end

   // Register everything
   always_ff @(posedge core_clk_i)
   begin
      if (!rst_n_i)
      begin
         st_q <= ecf_pkg::ST_IDLE;
         decim_q <= ecf_pkg::DECIM_RST;
         blank_q <= ecf_pkg::BLANK_RST;
         mode_q <= ecf_pkg::MODE_RST;
         burst_pulse_count_q <= ecf_pkg::PULSE_RST;
         on_a_q <= ecf_pkg::HALF_RST;
         off_a_q <= ecf_pkg::HALF_RST;
         on_b_q <= ecf_pkg::HALF_RST;
         off_b_q <= ecf_pkg::HALF_RST;
         coef_q <= 80'h0;
         rd_ptr_q <= 10'h000;
         wr_ptr_q <= 10'h000;
         tick_q <= 6'h00;
         dec_q <= 8'h00;
         blk_q <= 8'h00;
         hi_q <= 1'b0;
         nib_q <= 4'h0;
         full_q <= 1'b0;
         upd_q <= 1'b0;
         start_q <= 1'b0;
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end
      else
      begin
         st_q <= st_d;
         decim_q <= decim_d;
         blank_q <= blank_d;
         mode_q <= mode_d;
         burst_pulse_count_q <= burst_pulse_count_d;
         on_a_q <= on_a_d;
         off_a_q <= off_a_d;
         on_b_q <= on_b_d;
         off_b_q <= off_b_d;
         coef_q <= coef_d;
         rd_ptr_q <= rd_ptr_d;
         wr_ptr_q <= wr_ptr_d;
         tick_q <= tick_d;
         dec_q <= dec_d;
         blk_q <= blk_d;
         hi_q <= hi_d;
         nib_q <= nib_d;
         full_q <= full_d;
         upd_q <= upd_d;
         start_q <= start_d;
         prdata <= prdata_d;
         pready <= pready_d;
         pslverr <= pslverr_d;
      end
   end
   assign fifo_update_o = upd_q;
   assign bandpass_b1_o = {bandpass_b1_high_q, bandpass_b1_low_q};
   assign bandpass_a2_o = {bandpass_a2_high_q, bandpass_a2_low_q};
   assign bandpass_a3_o = {bandpass_a3_high_q, bandpass_a3_low_q};
   assign lowpass_b1_o = {lowpass_b1_high_q, lowpass_b1_low_q};
   assign lowpass_a2_o = {lowpass_a2_high_q, lowpass_a2_low_q};

   // Sample byte store
   ecf_ram u_ram (
      .core_clk_i(core_clk_i),
      .we_i(we),
      .waddr_i(wr_ptr_q),
      .wdata_i(wbyte),
      .raddr_i(rd_ptr_q),
      .rdata_o(ram_rdata)
   );

   // Drive burst generator
   ecf_burst u_burst (
      .core_clk_i(core_clk_i),
      .rst_n_i(rst_n_i),
      .start_i(start_q),
      .pulses_i(burst_pulse_count_q),
      .on_a_i(on_a_q),
      .off_a_i(off_a_q),
      .on_b_i(on_b_q),
      .off_b_i(off_b_q),
      .drv_a_o(drv_a_o),
      .drv_b_o(drv_b_o),
      .done_o(burst_done)
   );

   // Checks
   a_ptr_bound: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      wr_ptr_q <= ecf_pkg::FIFO_LAST + 10'h001) else $error("write pointer past capacity");
   a_full_stops: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      full_q && st_q == ecf_pkg::ST_IDLE && !start_q |=> $stable(wr_ptr_q)) else $error("pointer moved when full");
   a_blank_nowrite: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      st_q == ecf_pkg::ST_BLANK |-> !we) else $error("store during blanking");
   a_upd_step: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      we |=> upd_q && wr_ptr_q == $past(wr_ptr_q) + 10'h001) else $error("pointer step wrong");
   a_write_tick: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      we && !hi_q |-> tick_q == 6'h00) else $error("write off sample tick");
   a_pair_follow: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      we && hi_d |=> we && hi_q) else $error("upper byte not paired");
   a_mid_slice: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      we && mode_q == ecf_pkg::MODE_MID8 |-> wbyte == echo_sample_i[10:3]) else $error("mid slice wrong");
   a_low_slice: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      we && mode_q == ecf_pkg::MODE_LOW8 |-> wbyte == echo_sample_i[7:0]) else $error("low slice wrong");
   a_drv_excl: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      !(drv_a_o && drv_b_o)) else $error("both drivers on");
   a_start_burst: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      st_q == ecf_pkg::ST_IDLE && start_q |=> st_q == ecf_pkg::ST_BURST) else $error("start ignored");
endmodule
`default_nettype wire

// [ecf_pkg.sv]
`default_nettype none
package ecf_pkg;
   // Register byte addresses
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_DECIM = 8'h04;
   localparam logic [7:0] ADDR_BLANK = 8'h08;
   localparam logic [7:0] ADDR_FIFO_MODE = 8'h0C;
   localparam logic [7:0] ADDR_PULSE = 8'h10;
   localparam logic [7:0] ADDR_ON_A = 8'h14;
   localparam logic [7:0] ADDR_OFF_A = 8'h18;
   localparam logic [7:0] ADDR_ON_B = 8'h1C;
   localparam logic [7:0] ADDR_OFF_B = 8'h20;
   localparam logic [7:0] ADDR_BP_B1 = 8'h24;
   localparam logic [7:0] ADDR_BP_A2 = 8'h28;
   localparam logic [7:0] ADDR_BP_A3 = 8'h2C;
   localparam logic [7:0] ADDR_LP_B1 = 8'h30;
   localparam logic [7:0] ADDR_LP_A2 = 8'h34;
   localparam logic [7:0] ADDR_STATUS = 8'h38;
   localparam logic [7:0] ADDR_RD_PTR = 8'h3C;
   localparam logic [7:0] ADDR_RD_DATA = 8'h40;
   // Fifo sizing and sample format
   localparam int FIFO_BYTES = 768;
   localparam int PTR_W = 10;
   localparam logic [9:0] FIFO_LAST = 10'h2FF;
   localparam int SAMPLE_W = 12;
   localparam int MID_LSB = 3;
   // Storage mode codes
   localparam logic [7:0] MODE_MID8 = 8'h07;
   localparam logic [7:0] MODE_LOW8 = 8'h06;
   // Converter sample rate and clock
   localparam int CLK_HZ = 50000000;
   localparam int SAMPLE_HZ = 1000000;
   localparam logic [5:0] SAMPLE_DIV = 6'(CLK_HZ / SAMPLE_HZ);
   // Reset values and blanking maximum
   localparam logic [7:0] DECIM_RST = 8'h28;
   localparam logic [7:0] BLANK_RST = 8'h00;
   localparam logic [7:0] BLANK_MAX = 8'hFF;
   localparam logic [7:0] MODE_RST = 8'h06;
   localparam logic [7:0] PULSE_RST = 8'h01;
   localparam logic [15:0] HALF_RST = 16'h008A;
   // Control bit
   localparam int CTRL_START = 0;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_BURST = 2'b01,
      ST_BLANK = 2'b10,
      ST_STORE = 2'b11
   } ecf_state_type;
endpackage
`default_nettype wire

// [ecf_ram.sv]
`default_nettype none
module ecf_ram (
   input wire logic core_clk_i, // System clock
   input wire logic we_i, // Write strobe
   input wire logic [9:0] waddr_i, // Write address
   input wire logic [7:0] wdata_i, // Write byte
   input wire logic [9:0] raddr_i, // Read address
   output logic [7:0] rdata_o // Registered read byte
);
   logic [7:0] mem [0:ecf_pkg::FIFO_BYTES-1];
   logic [7:0] rdata_q;
   // Byte store, registered read
   always_ff @(posedge core_clk_i)
   begin
      if (we_i)
      begin
         mem[waddr_i] <= wdata_i;
      end
      rdata_q <= mem[raddr_i];
   end
   assign rdata_o = rdata_q;
endmodule
`default_nettype wire

// [ecf_burst.sv]
`default_nettype none
module ecf_burst (
   input wire logic core_clk_i, // System clock
   input wire logic rst_n_i, // Sync reset, low
   input wire logic start_i, // Start burst pulse
   input wire logic [7:0] pulses_i, // Pulse count
   input wire logic [15:0] on_a_i, // Out A on time
   input wire logic [15:0] off_a_i, // Out A off time
   input wire logic [15:0] on_b_i, // Out B on time
   input wire logic [15:0] off_b_i, // Out B off time
   output logic drv_a_o, // Low side A
   output logic drv_b_o, // Low side B
   output logic done_o // Burst done pulse
);
   logic busy_q, busy_d, ph_q, ph_d, done_q, done_d;
   logic [15:0] cnt_q, cnt_d;
   logic [7:0] left_q, left_d;
   logic [15:0] lim;
   // Half period sequencing, A on phase drives A, off phase drives B
   always_comb
   begin
      busy_d = busy_q;
      ph_d = ph_q;
      cnt_d = cnt_q + 16'h0001;
      left_d = left_q;
      done_d = 1'b0;
      lim = ph_q ? ((off_a_i > off_b_i) ? off_a_i : off_b_i) : ((on_a_i > on_b_i) ? on_a_i : on_b_i);
      if (!busy_q)
      begin
         cnt_d = 16'h0000;
         if (start_i && pulses_i != 8'h00)
         begin
            busy_d = 1'b1;
            ph_d = 1'b0;
            left_d = pulses_i;
         end
      end
      else if (cnt_q + 16'h0001 >= lim)
      begin
         cnt_d = 16'h0000;
         ph_d = ~ph_q;
         if (ph_q)
         begin
            left_d = left_q - 8'h01;
            if (left_q == 8'h01)
            begin
               busy_d = 1'b0;
               done_d = 1'b1;
            end
         end
      end
   end
   always_ff @(posedge core_clk_i)
   begin
      if (!rst_n_i)
      begin
         busy_q <= 1'b0;
         ph_q <= 1'b0;
         cnt_q <= 16'h0000;
         left_q <= 8'h00;
         done_q <= 1'b0;
         drv_a_o <= 1'b0;
         drv_b_o <= 1'b0;
      end
      else
      begin
         busy_q <= busy_d;
         ph_q <= ph_d;
         cnt_q <= cnt_d;
         left_q <= left_d;
         done_q <= done_d;
         drv_a_o <= busy_d && !ph_d;
         drv_b_o <= busy_d && ph_d;
      end
   end
   assign done_o = done_q;
endmodule
`default_nettype wire

// [ecf_xdcr_model.sv]
`default_nettype none
module ecf_xdcr_model (
   input wire logic core_clk_i, // System clock
   input wire logic clr_i, // Clear pulse count
   input wire logic drv_a_i, // Low side drive A
   input wire logic drv_b_i, // Low side drive B
   input wire logic [11:0] echo_level_i, // Quiet echo level
   output logic [11:0] echo_sample_o, // Filtered echo to device
   output logic [7:0] pulse_cnt_o, // Drive A pulses seen
   output logic [15:0] high_len_o // Last drive A on width
);
   timeunit 1ns;
   timeprecision 1ps;
   logic drv_a_prev = 1'b0;
   logic [15:0] run_len = 16'h0000;
   // Echo saturates while the transformer is driven
   always_comb echo_sample_o = (drv_a_i | drv_b_i) ? 12'hFFF : echo_level_i;
   // Pulse count and on width of drive A
   initial
   begin
      pulse_cnt_o = 8'h00;
      high_len_o = 16'h0000;
   end
   always @(posedge core_clk_i)
   begin
      drv_a_prev <= drv_a_i;
      run_len <= drv_a_i ? run_len + 16'h0001 : 16'h0000;
      if (clr_i)
         pulse_cnt_o <= 8'h00;
      else if (drv_a_i & ~drv_a_prev)
         pulse_cnt_o <= pulse_cnt_o + 8'h01;
      if (~drv_a_i & drv_a_prev)
         high_len_o <= run_len;
   end
endmodule
`default_nettype wire

// [testbench.sv]
`default_nettype none
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin n_mismatch++; \
   $display("FAIL t=%0t got=%h exp=%h", $time, (a), (e)); end end
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int TIMEOUT = 100000;
   localparam int TICK = int'(ecf_pkg::SAMPLE_DIV);
   logic core_clk_i = 1'b0, rst_n_i = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, r;
   logic pready, pslverr, e, drv_a_o, drv_b_o, fifo_update_o, xclr = 1'b0, mon_clr = 1'b0;
   logic [11:0] echo_sample_i, echo_level = 12'hABC;
   logic [15:0] bandpass_b1_o, bandpass_a2_o, bandpass_a3_o, lowpass_b1_o, lowpass_a2_o, high_len;
   logic [7:0] pulse_cnt;
   logic [15:0] cf [5] = '{16'h032D, 16'hEC3D, 16'hF9A5, 16'h2D68, 16'h2530};
   int n_mismatch = 0, check_count = 0, cyc = 0, upd_n = 0, first_upd = 0, last_upd = 0;
   int last_drv = 0, gap_err = 0, exp_gap = 0;
   ecf_top dut_u (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .echo_sample_i(echo_sample_i), .drv_a_o(drv_a_o), .drv_b_o(drv_b_o),
      .fifo_update_o(fifo_update_o), .bandpass_b1_o(bandpass_b1_o), .bandpass_a2_o(bandpass_a2_o),
      .bandpass_a3_o(bandpass_a3_o), .lowpass_b1_o(lowpass_b1_o), .lowpass_a2_o(lowpass_a2_o));
   ecf_xdcr_model xdcr_u (.core_clk_i(core_clk_i), .clr_i(xclr), .drv_a_i(drv_a_o), .drv_b_i(drv_b_o),
      .echo_level_i(echo_level), .echo_sample_o(echo_sample_i), .pulse_cnt_o(pulse_cnt),
      .high_len_o(high_len));
   // Clock
   always #10 core_clk_i = ~core_clk_i;
   // Store pulse monitor and hang guard
   always @(posedge core_clk_i)
   begin
      cyc <= cyc + 1;
      if (drv_a_o | drv_b_o)
         last_drv <= cyc;
      if (mon_clr)
      begin
         upd_n <= 0;
         gap_err <= 0;
      end
      else if (fifo_update_o === 1'b1)
      begin
         if (upd_n == 0)
            first_upd <= cyc;
         else if (exp_gap != 0 && cyc - last_upd != exp_gap)
            gap_err <= gap_err + 1;
         last_upd <= cyc;
         upd_n <= upd_n + 1;
      end
      if (cyc == TIMEOUT)
      begin
         n_mismatch++;
         close_out();
      end
   end
   // Report and end
   task automatic close_out();
      $display("mismatches=%0d checks=%0d", n_mismatch, check_count);
      if (n_mismatch == 0 && check_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // One APB transfer, waits for pready
   task automatic apb(input logic wr_en, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] rd, output logic err);
      int n;
      n = 0;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr_en;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk_i);
      penable <= 1'b1;
      @(posedge core_clk_i);
      while (pready !== 1'b1 && n < 20)
      begin
         n++;
         @(posedge core_clk_i);
      end
      rd = prdata;
      err = pslverr;
      `CHK(n < 20, 1'b1)
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge core_clk_i);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d, r, e);
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] x);
      apb(1'b0, a, 32'h0, r, e);
      `CHK(r, x)
   endtask
   // Point the read port, then a spacer access
   task automatic seek(input logic [31:0] p);
      wr(ecf_pkg::ADDR_RD_PTR, p);
      apb(1'b0, ecf_pkg::ADDR_STATUS, 32'h0, r, e);
   endtask
   task automatic measure(input logic [7:0] mode, input logic [7:0] blank, input int gap);
      wr(ecf_pkg::ADDR_FIFO_MODE, {24'h0, mode});
      wr(ecf_pkg::ADDR_BLANK, {24'h0, blank});
      exp_gap <= gap;
      mon_clr <= 1'b1;
      xclr <= 1'b1;
      @(posedge core_clk_i);
      mon_clr <= 1'b0;
      xclr <= 1'b0;
      wr(ecf_pkg::ADDR_CTRL, 32'h1);
   endtask
   // Main sequence
   initial
   begin
      repeat (2) @(posedge core_clk_i);
      rst_n_i <= 1'b1;
      @(posedge core_clk_i);
      rd_chk(ecf_pkg::ADDR_DECIM, 32'h28);
      rd_chk(ecf_pkg::ADDR_BLANK, 32'h0);
      rd_chk(ecf_pkg::ADDR_FIFO_MODE, 32'h06);
      rd_chk(ecf_pkg::ADDR_PULSE, 32'h01);
      for (int i = 0; i < 4; i++)
         rd_chk(ecf_pkg::ADDR_ON_A + 8'(4 * i), 32'h8A);
      apb(1'b0, 8'h44, 32'h0, r, e);
      `CHK({e, r}, 33'h100000000)
      for (int i = 0; i < 5; i++)
      begin
         wr(ecf_pkg::ADDR_BP_B1 + 8'(4 * i), {16'h0, cf[i]});
         rd_chk(ecf_pkg::ADDR_BP_B1 + 8'(4 * i), {16'h0, cf[i]});
      end
      `CHK({bandpass_b1_o, bandpass_a2_o, bandpass_a3_o}, {cf[0], cf[1], cf[2]})
      `CHK({lowpass_b1_o, lowpass_a2_o}, {cf[3], cf[4]})
      // Full run, middle slice, two pulses
      wr(ecf_pkg::ADDR_PULSE, 32'h2);
      for (int i = 0; i < 4; i++)
         wr(ecf_pkg::ADDR_ON_A + 8'(4 * i), 32'h6);
      wr(ecf_pkg::ADDR_DECIM, 32'h1);
      measure(ecf_pkg::MODE_MID8, 8'h02, TICK);
      while (upd_n < ecf_pkg::FIFO_BYTES)
         @(posedge core_clk_i);
      repeat (300) @(posedge core_clk_i);
      `CHK(upd_n, ecf_pkg::FIFO_BYTES)
      `CHK(gap_err, 0)
      `CHK(pulse_cnt, 8'h02)
      `CHK(high_len, 16'h0006)
      `CHK(first_upd - last_drv >= 2 * TICK && first_upd - last_drv <= 5 * TICK, 1'b1)
      apb(1'b0, ecf_pkg::ADDR_STATUS, 32'h0, r, e);
      `CHK(r[2:0], {1'b1, ecf_pkg::ST_IDLE})
      seek(32'h0);
      rd_chk(ecf_pkg::ADDR_RD_DATA, 32'h57);
      seek(32'h2FF);
      rd_chk(ecf_pkg::ADDR_RD_DATA, 32'h57);
      // Full 12-bit run, longest blanking, one pulse
      wr(ecf_pkg::ADDR_PULSE, 32'h1);
      measure(8'h00, ecf_pkg::BLANK_MAX, 0);
      while (upd_n < ecf_pkg::FIFO_BYTES)
         @(posedge core_clk_i);
      repeat (300) @(posedge core_clk_i);
      `CHK(upd_n, ecf_pkg::FIFO_BYTES)
      `CHK((last_upd - first_upd + TICK / 2) / TICK, 383)
      `CHK(pulse_cnt, 8'h01)
      `CHK(first_upd - last_drv >= 255 * TICK && first_upd - last_drv <= 258 * TICK, 1'b1)
      seek(32'h0);
      rd_chk(ecf_pkg::ADDR_RD_DATA, 32'hBC);
      rd_chk(ecf_pkg::ADDR_RD_DATA, 32'h0A);
      // Low byte mode, checked while storing
      echo_level <= 12'h5C3;
      wr(ecf_pkg::ADDR_DECIM, 32'h2);
      measure(ecf_pkg::MODE_LOW8, 8'h00, 2 * TICK);
      while (upd_n < 4)
         @(posedge core_clk_i);
      apb(1'b0, ecf_pkg::ADDR_STATUS, 32'h0, r, e);
      `CHK(r[2:0], {1'b0, ecf_pkg::ST_STORE})
      `CHK(gap_err, 0)
      seek(32'h1);
      rd_chk(ecf_pkg::ADDR_RD_DATA, 32'hC3);
      close_out();
   end
endmodule
`default_nettype wire
